// ---- hdl/nbai_pkg.sv ----
// Package of constants and types for the NAND bus host controller
// Contract
// - Address latch select is held high for each address byte.
// - Command latch select is held high for each command byte.
// - All bytes share one 8-bit bidirectional bus, sorted by strobes and selects.
// - Address byte one holds column 7..0, byte two column 11..8.
// - Upper four lines of the second address byte are driven low.
// - Bytes three and four carry row bits 7..0 then 15..8.
// - Only command codes of the defined command set are ever issued.
package nbai_pkg;

    localparam int CLK_PERIOD_NS        = 100;
    localparam int READ_ACCESS_DELAY_NS = 20;
    localparam int BUSY_SETTLE_NS       = 100;
    localparam int SYNC_STAGES          = 2;

    // Least times round up, never below one cycle
    localparam int READ_ACCESS_CYC_I = (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACCESS_CYC   = (READ_ACCESS_CYC_I < 1) ? 1 : READ_ACCESS_CYC_I;
    localparam int BUSY_SETTLE_CYC_I = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_SETTLE_CYC   = (BUSY_SETTLE_CYC_I < 1) ? 1 : BUSY_SETTLE_CYC_I;

    localparam logic [3:0] READ_WAIT_CNT = 4'(READ_ACCESS_CYC + SYNC_STAGES);
    localparam logic [3:0] BUSY_WAIT_CNT = 4'(BUSY_SETTLE_CYC + SYNC_STAGES);

    localparam int BUS_W        = 8;
    localparam int COL_W        = 12;
    localparam int ROW_W        = 16;
    localparam int COL_HI_LSB   = 8;
    localparam int PAGE_BYTES   = 2112;
    localparam int MAIN_BYTES   = 2048;
    localparam int SPARE_BYTES  = 64;
    localparam int BLOCK_COUNT  = 1024;
    localparam int PAGES_PER_BLK = 64;

    localparam logic [COL_W-1:0] COL_LIMIT = 12'(MAIN_BYTES + SPARE_BYTES);
    localparam logic [2:0] ADDR_COL_BYTES  = 3'h2;
    localparam logic [2:0] ADDR_FULL_BYTES = 3'h4;

    // Defined command set
    localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COPY_READ    = 8'h35;
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_RESET        = 8'hFF;
    localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_RAND_IN      = 8'h85;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONF   = 8'hD0;
    localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
    localparam logic [7:0] CMD_RAND_OUT_CNF = 8'hE0;
    localparam logic [7:0] CMD_READ_PARAM   = 8'hEC;

    typedef enum logic [2:0] {
        OP_CMD,
        OP_ADDR_COL,
        OP_ADDR_FULL,
        OP_DATA_WR,
        OP_DATA_RD,
        OP_WAIT_READY
    } nbai_op_t;

    typedef struct packed {
        nbai_op_t         op;
        logic [BUS_W-1:0] byte_val;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } nbai_req_t;

    typedef struct packed {
        logic [BUS_W-1:0] rd_data;
        logic             err;
    } nbai_rsp_t;

    typedef struct packed {
        logic             ce_n;
        logic             cle;
        logic             ale;
        logic             we_n;
        logic             re_n;
        logic             wp_n;
        logic [BUS_W-1:0] io_o;
        logic             io_oe;
    } nbai_pins_t;

    localparam nbai_pins_t PINS_RESET = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                          re_n: 1'b1, wp_n: 1'b0, io_o: 8'h00, io_oe: 1'b0};

endpackage : nbai_pkg

// ---- hdl/nbai_sync.sv ----
// Two-flop synchroniser for the flash pin inputs
`timescale 1ns/1ps
module nbai_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             MCLK,    // System clock
    input  wire logic             RST_N,   // Asynchronous reset, active low
    input  wire logic [WIDTH-1:0] D_ASYNC, // Pin level from outside
    output logic      [WIDTH-1:0] Q_SYNC   // Level in clock domain
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= D_ASYNC;
            sync_reg <= meta_reg;
        end
    end

    assign Q_SYNC = sync_reg;

endmodule : nbai_sync

// ---- hdl/nbai_host.sv ----
// NAND bus host controller: turns byte requests into flash pin cycles
`timescale 1ns/1ps
module nbai_host
    import nbai_pkg::*;
(
    input  wire logic                 MCLK,        // System clock, 10 MHz
    input  wire logic                 RST_N,       // Asynchronous reset, active low
    input  wire logic                 REQ_VALID,   // Request offered
    input  nbai_pkg::nbai_req_t       REQ,         // Request contents
    output logic                      REQ_READY,   // Request can be taken
    output logic                      RSP_VALID,   // One-cycle completion pulse
    output nbai_pkg::nbai_rsp_t       RSP,         // Read byte and refusal flag
    input  wire logic                 PROG_ENABLE, // High allows program and erase
    output logic                      NAND_CE_N,   // Chip select, active low
    output logic                      NAND_CLE,    // Command latch select
    output logic                      NAND_ALE,    // Address latch select
    output logic                      NAND_WE_N,   // Write strobe, active low
    output logic                      NAND_RE_N,   // Read strobe, active low
    output logic                      NAND_WP_N,   // Program lock, active low
    output logic [7:0]                NAND_IO_O,   // Bus value driven
    output logic                      NAND_IO_OE,  // Bus driven while high
    input  wire logic [7:0]           NAND_IO_I,   // Bus value seen
    input  wire logic                 NAND_RB_N    // Ready/busy, pulled up
);
    import nbai_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WR_SETUP,
        ST_WR_LOW,
        ST_WR_HOLD,
        ST_RD_LOW,
        ST_RD_HIGH,
        ST_BUSY_WAIT
    } nbai_state_t;

    function automatic logic cmd_defined(input logic [7:0] c);
        unique case (c)
            CMD_READ_SETUP, CMD_READ_CONFIRM, CMD_COPY_READ, CMD_READ_ID,
            CMD_READ_STATUS, CMD_RESET, CMD_PROG_SETUP, CMD_PROG_CONFIRM,
            CMD_RAND_IN, CMD_ERASE_SETUP, CMD_ERASE_CONF, CMD_RAND_OUT,
            CMD_RAND_OUT_CNF, CMD_READ_PARAM: cmd_defined = 1'b1;
            default:                          cmd_defined = 1'b0;
        endcase
    endfunction : cmd_defined

    function automatic logic [7:0] addr_byte(input logic [COL_W-1:0] col,
                                             input logic [ROW_W-1:0] row,
                                             input logic [2:0]       idx);
        unique case (idx)
            3'h0:    addr_byte = col[7:0];
            3'h1:    addr_byte = {4'h0, col[COL_W-1:COL_HI_LSB]};
            3'h2:    addr_byte = row[7:0];
            default: addr_byte = row[ROW_W-1:8];
        endcase
    endfunction : addr_byte

    nbai_state_t state_reg;
    nbai_state_t state_next;
    nbai_req_t   req_reg;
    nbai_req_t   req_next;
    nbai_pins_t  pins_reg;
    nbai_pins_t  pins_next;
    nbai_rsp_t   rsp_reg;
    nbai_rsp_t   rsp_next;
    logic        rsp_valid_reg;
    logic        rsp_valid_next;
    logic        ready_reg;
    logic        ready_next;
    logic [2:0]  idx_reg;
    logic [2:0]  idx_next;
    logic [2:0]  total_reg;
    logic [2:0]  total_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [8:0]  pin_sync;
    logic [7:0]  io_sync;
    logic        rb_sync;

    // Busy line and data bus arrive from another timing domain
    nbai_sync #(.WIDTH(9)) u_sync (
        .MCLK    (MCLK),
        .RST_N   (RST_N),
        .D_ASYNC ({NAND_RB_N, NAND_IO_I}),
        .Q_SYNC  (pin_sync)
    );

    assign io_sync = pin_sync[7:0];
    assign rb_sync = pin_sync[8];

    always_comb begin
        state_next     = state_reg;
        req_next       = req_reg;
        pins_next      = pins_reg;
        rsp_next       = rsp_reg;
        rsp_valid_next = 1'b0;
        idx_next       = idx_reg;
        total_next     = total_reg;
        cnt_next       = cnt_reg;
        pins_next.wp_n = PROG_ENABLE;

        unique case (state_reg)
            ST_IDLE: begin
                if (REQ_VALID) begin
                    req_next   = REQ;
                    idx_next   = 3'h0;
                    total_next = 3'h1;
                    rsp_next   = '0;
                    unique case (REQ.op)
                        OP_CMD: begin
                            if (cmd_defined(REQ.byte_val)) begin
                                pins_next.ce_n  = 1'b0;
                                pins_next.cle   = 1'b1;
                                pins_next.io_o  = REQ.byte_val;
                                pins_next.io_oe = 1'b1;
                                state_next      = ST_WR_SETUP;
                            end else begin
                                rsp_next.err   = 1'b1;
                                rsp_valid_next = 1'b1;
                            end
                        end
                        OP_ADDR_COL, OP_ADDR_FULL: begin
                            // Column must fall inside main plus spare area
                            if (REQ.col < COL_LIMIT) begin
                                total_next      = (REQ.op == OP_ADDR_FULL) ? ADDR_FULL_BYTES
                                                                           : ADDR_COL_BYTES;
                                pins_next.ce_n  = 1'b0;
                                pins_next.ale   = 1'b1;
                                pins_next.io_o  = addr_byte(REQ.col, REQ.row, 3'h0);
                                pins_next.io_oe = 1'b1;
                                state_next      = ST_WR_SETUP;
                            end else begin
                                rsp_next.err   = 1'b1;
                                rsp_valid_next = 1'b1;
                            end
                        end
                        OP_DATA_WR: begin
                            // Both selects low marks a data byte
                            pins_next.ce_n  = 1'b0;
                            pins_next.io_o  = REQ.byte_val;
                            pins_next.io_oe = 1'b1;
                            state_next      = ST_WR_SETUP;
                        end
                        OP_DATA_RD: begin
                            pins_next.ce_n = 1'b0;
                            pins_next.re_n = 1'b0;
                            cnt_next       = READ_WAIT_CNT;
                            state_next     = ST_RD_LOW;
                        end
                        OP_WAIT_READY: begin
                            // Busy may assert late; settle before polling
                            cnt_next   = BUSY_WAIT_CNT;
                            state_next = ST_BUSY_WAIT;
                        end
                        default: begin
                            rsp_next.err   = 1'b1;
                            rsp_valid_next = 1'b1;
                        end
                    endcase
                end
            end
            ST_WR_SETUP: begin
                pins_next.we_n = 1'b0;
                state_next     = ST_WR_LOW;
            end
            ST_WR_LOW: begin
                pins_next.we_n = 1'b1;
                state_next     = ST_WR_HOLD;
            end
            ST_WR_HOLD: begin
                if (idx_reg + 3'h1 < total_reg) begin
                    idx_next       = idx_reg + 3'h1;
                    pins_next.io_o = addr_byte(req_reg.col, req_reg.row, idx_reg + 3'h1);
                    state_next     = ST_WR_SETUP;
                end else begin
                    pins_next.ce_n  = 1'b1;
                    pins_next.cle   = 1'b0;
                    pins_next.ale   = 1'b0;
                    pins_next.io_oe = 1'b0;
                    rsp_valid_next  = 1'b1;
                    state_next      = ST_IDLE;
                end
            end
            ST_RD_LOW: begin
                if (cnt_reg == 4'h1) begin
                    // Next strobe yields the following column
                    rsp_next.rd_data = io_sync;
                    pins_next.re_n   = 1'b1;
                    state_next       = ST_RD_HIGH;
                end
                cnt_next = cnt_reg - 4'h1;
            end
            ST_RD_HIGH: begin
                pins_next.ce_n = 1'b1;
                rsp_valid_next = 1'b1;
                state_next     = ST_IDLE;
            end
            ST_BUSY_WAIT: begin
                if (cnt_reg != 4'h0) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (rb_sync) begin
                    rsp_valid_next = 1'b1;
                    state_next     = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        ready_next = (state_next == ST_IDLE) && !(state_reg == ST_IDLE && REQ_VALID);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg     <= ST_IDLE;
            req_reg       <= '0;
            pins_reg      <= PINS_RESET;
            rsp_reg       <= '0;
            rsp_valid_reg <= 1'b0;
            ready_reg     <= 1'b0;
            idx_reg       <= 3'h0;
            total_reg     <= 3'h0;
            cnt_reg       <= 4'h0;
        end else begin
            state_reg     <= state_next;
            req_reg       <= req_next;
            pins_reg      <= pins_next;
            rsp_reg       <= rsp_next;
            rsp_valid_reg <= rsp_valid_next;
            ready_reg     <= ready_next;
            idx_reg       <= idx_next;
            total_reg     <= total_next;
            cnt_reg       <= cnt_next;
        end
    end

    assign REQ_READY  = ready_reg;
    assign RSP_VALID  = rsp_valid_reg;
    assign RSP        = rsp_reg;
    assign NAND_CE_N  = pins_reg.ce_n;
    assign NAND_CLE   = pins_reg.cle;
    assign NAND_ALE   = pins_reg.ale;
    assign NAND_WE_N  = pins_reg.we_n;
    assign NAND_RE_N  = pins_reg.re_n;
    assign NAND_WP_N  = pins_reg.wp_n;
    assign NAND_IO_O  = pins_reg.io_o;
    assign NAND_IO_OE = pins_reg.io_oe;

endmodule : nbai_host

// ---- dv/nbai_host_sva.sv ----
// Port assertions for the NAND bus host controller
`timescale 1ns/1ps
module nbai_host_sva
    import nbai_pkg::*;
(
    input wire logic             MCLK,        // Clock
    input wire logic             RST_N,       // Reset
    input wire logic             REQ_VALID,   // Offer
    input nbai_pkg::nbai_req_t   REQ,         // Request
    input wire logic             REQ_READY,   // Idle
    input wire logic             RSP_VALID,   // Done pulse
    input nbai_pkg::nbai_rsp_t   RSP,         // Answer
    input wire logic             PROG_ENABLE, // Unlock
    input wire logic             NAND_CE_N,   // Select
    input wire logic             NAND_CLE,    // Cmd latch
    input wire logic             NAND_ALE,    // Addr latch
    input wire logic             NAND_WE_N,   // Write strobe
    input wire logic             NAND_RE_N,   // Read strobe
    input wire logic             NAND_WP_N,   // Lock
    input wire logic [7:0]       NAND_IO_O,   // Bus out
    input wire logic             NAND_IO_OE   // Bus drive
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    sequence bad_cmd_s;
        REQ_VALID && REQ_READY && REQ.op == OP_CMD && !(REQ.byte_val inside {8'h00, 8'h30, 8'h35,
            8'h90, 8'h70, 8'hFF, 8'h80, 8'h10, 8'h85, 8'h60, 8'hD0, 8'h05, 8'hE0, 8'hEC});
    endsequence
    sequence big_col_s;
        REQ_VALID && REQ_READY && REQ.op inside {OP_ADDR_COL, OP_ADDR_FULL} && REQ.col >= 12'h840;
    endsequence
    sequence wait_s;
        REQ_VALID && REQ_READY && REQ.op == OP_WAIT_READY;
    endsequence
    sequence re_low_s;
        $fell(NAND_RE_N) ##1 !NAND_RE_N;
    endsequence

    idle_float_a: assert property (
        REQ_READY |-> NAND_CE_N && !NAND_IO_OE && NAND_WE_N && NAND_RE_N) else $error("bus held while idle");
    we_pulse_a: assert property (
        $fell(NAND_WE_N) |=> $rose(NAND_WE_N)) else $error("write strobe not one cycle");
    latch_hold_a: assert property (
        $fell(NAND_WE_N) |-> $stable({NAND_CE_N, NAND_CLE, NAND_ALE, NAND_IO_O})
        ##1 $stable({NAND_CE_N, NAND_CLE, NAND_ALE, NAND_IO_O})) else $error("latch inputs moved");
    we_drive_a: assert property (
        !NAND_WE_N |-> !NAND_CE_N && NAND_IO_OE && NAND_RE_N && !(NAND_CLE && NAND_ALE))
        else $error("write strobe without bus");
    read_gate_a: assert property (
        !NAND_RE_N |-> !NAND_CE_N && !NAND_IO_OE && !NAND_CLE && !NAND_ALE) else $error("read with bus driven");
    re_pulse_a: assert property (
        re_low_s |-> ##[1:2] $rose(NAND_RE_N)) else $error("read strobe length wrong");
    wp_copy_a: assert property (
        $changed(PROG_ENABLE) |=> NAND_WP_N == $past(PROG_ENABLE)) else $error("lock not following enable");
    refuse_cmd_a: assert property (
        bad_cmd_s |=> RSP_VALID && RSP.err && NAND_CE_N) else $error("undefined command not refused");
    refuse_col_a: assert property (
        big_col_s |=> RSP_VALID && RSP.err) else $error("column past page not refused");
    busy_wait_a: assert property (
        wait_s |=> (!RSP_VALID)[*4] ##[1:400] RSP_VALID) else $error("ready wait answered wrongly");
endmodule : nbai_host_sva

bind nbai_host nbai_host_sva nbai_host_sva_i (.MCLK(MCLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .PROG_ENABLE(PROG_ENABLE), .NAND_CE_N(NAND_CE_N),
    .NAND_CLE(NAND_CLE), .NAND_ALE(NAND_ALE), .NAND_WE_N(NAND_WE_N), .NAND_RE_N(NAND_RE_N),
    .NAND_WP_N(NAND_WP_N), .NAND_IO_O(NAND_IO_O), .NAND_IO_OE(NAND_IO_OE));

// ---- dv/nbai_flash_model.sv ----
// Behavioural flash device on the far side of the pin bus
`timescale 1ns/1ps
module nbai_flash_model #(
    parameter int BUSY_NS   = 2000, // Array time, shortened
    parameter int ACCESS_NS = 20    // Read access delay
) (
    input  wire logic       ce_n,  // Select
    input  wire logic       cle,   // Cmd latch
    input  wire logic       ale,   // Addr latch
    input  wire logic       we_n,  // Write strobe
    input  wire logic       re_n,  // Read strobe
    input  wire logic       wp_n,  // Lock
    input  wire logic [7:0] io_o,  // Host value
    input  wire logic       io_oe, // Host drives
    output logic      [7:0] io_i,  // Wire level
    output logic            rb_n   // Ready/busy
);
    logic [7:0]  page [0:2111];
    logic [7:0]  cmd_reg = 8'h00;
    logic [7:0]  abyte [0:3];
    logic [2:0]  acnt = 3'h0;
    logic [11:0] col = 12'h000;
    logic [7:0]  dout = 8'h00;
    logic        valid = 1'h0;
    logic        busy = 1'h0;
    logic        din_open = 1'h0;
    int          arr_ops = 0;
    initial for (int i = 0; i < 2112; i++) page[i] = 8'(i) ^ 8'h5A;
    // Pull-up gives high; device only sinks
    assign rb_n = busy ? 1'h0 : 1'h1;
    // Released bus shows the inverse, never a held copy
    assign io_i = io_oe ? io_o : (valid && !ce_n && !re_n) ? dout : ~dout;
    always @(posedge we_n) begin
        if (!ce_n) begin
            if (cle) begin
                cmd_reg = io_i;
                acnt = 3'h0;
                if (io_i == 8'h80 || io_i == 8'h85) din_open = 1'h1;
                if (io_i == 8'h10) din_open = 1'h0;
                if (wp_n && (io_i == 8'h10 || io_i == 8'hD0)) arr_ops++;
                if (io_i == 8'h30 || wp_n && (io_i == 8'h10 || io_i == 8'hD0)) begin
                    busy = 1'h1;
                    busy <= #(BUSY_NS) 1'h0;
                end
            end else if (ale) begin
                if (acnt < 3'h4) abyte[acnt[1:0]] = io_i;
                if (acnt == 3'h1) col = {io_i[3:0], abyte[0]};
                if (acnt < 3'h4) acnt++;
            end else if (din_open) begin
                page[col] = io_i;
                col++;
            end
        end
    end
    always @(negedge re_n) begin
        // Select falls on the same edge as the strobe; let it settle first
        #1;
        if (!ce_n && !busy && !re_n) begin
            dout <= #(ACCESS_NS - 1) page[col];
            valid <= #(ACCESS_NS - 1) 1'h1;
            col++;
        end
    end
    always @(posedge re_n) valid = 1'h0;
endmodule : nbai_flash_model

// ---- dv/nbai_host_tb_top.sv ----
// Self-checking bench for the NAND bus host controller
`timescale 1ns/1ps
module nbai_host_tb_top;
    import nbai_pkg::*;
    logic       mclk = 1'h0;
    logic       rst_n = 1'h0;
    logic       req_valid = 1'h0;
    logic       prog_enable = 1'h0;
    nbai_req_t  req = '0;
    nbai_rsp_t  rsp, got;
    logic       req_ready, rsp_valid, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
    logic [7:0] io_o, io_i;
    int         fail_count = 0;
    int         cmp_count = 0;
    logic [7:0] codes [14] = '{8'h00, 8'h30, 8'h35, 8'h90, 8'h70, 8'hFF, 8'h80, 8'h10, 8'h85, 8'h60,
                               8'hD0, 8'h05, 8'hE0, 8'hEC};
    always #50 mclk = ~mclk;
    nbai_host nbai_host_i (.MCLK(mclk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP(rsp), .PROG_ENABLE(prog_enable), .NAND_CE_N(ce_n), .NAND_CLE(cle),
        .NAND_ALE(ale), .NAND_WE_N(we_n), .NAND_RE_N(re_n), .NAND_WP_N(wp_n), .NAND_IO_O(io_o),
        .NAND_IO_OE(io_oe), .NAND_IO_I(io_i), .NAND_RB_N(rb_n));
    nbai_flash_model nbai_flash_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .wp_n(wp_n), .io_o(io_o), .io_oe(io_oe), .io_i(io_i), .rb_n(rb_n));

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic do_req(input nbai_op_t op, input logic [7:0] b, input logic [11:0] c, input logic [15:0] r);
        int   n;
        logic took;
        n = 0;
        @(posedge mclk);
        req_valid <= 1'h1;
        req <= '{op: op, byte_val: b, col: c, row: r};
        do begin
            @(posedge mclk);
            n++;
        end while (req_ready !== 1'h1 && n < 100);
        // Offer must have been taken, not merely dropped at the limit
        took = req_ready;
        req_valid <= 1'h0;
        do begin
            @(negedge mclk);
            n++;
        end while (rsp_valid !== 1'h1 && n < 400);
        got = rsp;
        if (n >= 400 || took !== 1'h1) begin
            fail_count++;
            $display("unexpected timeout on request kind %0d", op);
            wrap_up();
        end
    endtask : do_req
    task automatic t_cmds;
        chk("power-on command", nbai_flash_model_i.cmd_reg, 8'h00);
        foreach (codes[i]) begin
            do_req(OP_CMD, codes[i], 12'h000, 16'h0000);
            chk("command latched", nbai_flash_model_i.cmd_reg, codes[i]);
            chk("command error", {7'h0, got.err}, 8'h00);
        end
        chk("locked array ops", 8'(nbai_flash_model_i.arr_ops), 8'h00);
        $display("test commands done");
    endtask : t_cmds
    task automatic t_refuse;
        do_req(OP_CMD, 8'h42, 12'h000, 16'h0000);
        chk("bad code error", {7'h0, got.err}, 8'h01);
        chk("bad code unseen", nbai_flash_model_i.cmd_reg, 8'hEC);
        do_req(OP_ADDR_COL, 8'h00, 12'h840, 16'h0000);
        chk("column past page", {7'h0, got.err}, 8'h01);
        do_req(OP_ADDR_COL, 8'h00, 12'h83F, 16'h0000);
        chk("last spare column", {7'h0, got.err}, 8'h00);
        chk("column high byte", nbai_flash_model_i.abyte[1], 8'h08);
        $display("test refusals done");
    endtask : t_refuse
    task automatic t_read;
        realtime t0;
        logic [7:0] exp_a [4] = '{8'h3D, 8'h08, 8'hE1, 8'hC3};
        do_req(OP_CMD, 8'h00, 12'h000, 16'h0000);
        do_req(OP_ADDR_FULL, 8'h00, 12'h83D, 16'hC3E1);
        foreach (exp_a[i]) chk("address byte", nbai_flash_model_i.abyte[i], exp_a[i]);
        chk("address count", {5'h0, nbai_flash_model_i.acnt}, 8'h04);
        do_req(OP_CMD, 8'h30, 12'h000, 16'h0000);
        t0 = $realtime;
        do_req(OP_WAIT_READY, 8'h00, 12'h000, 16'h0000);
        chk("busy wait", {7'h0, ($realtime - t0) >= 1800.0}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            do_req(OP_DATA_RD, 8'h00, 12'h000, 16'h0000);
            chk("read byte", got.rd_data, 8'(12'h83D + i) ^ 8'h5A);
        end
        $display("test read done");
    endtask : t_read
    task automatic t_write;
        @(posedge mclk);
        prog_enable <= 1'h1;
        do_req(OP_CMD, 8'h80, 12'h000, 16'h0000);
        do_req(OP_ADDR_FULL, 8'h00, 12'h020, 16'h0001);
        for (int i = 0; i < 3; i++) do_req(OP_DATA_WR, 8'hC0 + 8'(i), 12'h000, 16'h0000);
        do_req(OP_CMD, 8'h10, 12'h000, 16'h0000);
        do_req(OP_WAIT_READY, 8'h00, 12'h000, 16'h0000);
        for (int i = 0; i < 3; i++) chk("written byte", nbai_flash_model_i.page[32 + i], 8'hC0 + 8'(i));
        chk("unlocked array ops", 8'(nbai_flash_model_i.arr_ops), 8'h01);
        do_req(OP_DATA_WR, 8'h77, 12'h000, 16'h0000);
        chk("stray data byte", nbai_flash_model_i.page[35], 8'h23 ^ 8'h5A);
        $display("test write done");
    endtask : t_write

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (2) @(posedge mclk);
        t_cmds();
        t_refuse();
        t_read();
        t_write();
        wrap_up();
    end
endmodule : nbai_host_tb_top
